// File: logic/led_current_mode_registers.sv
// Behaviour
// R1 - Writing one to bit 7 of register 0x00 restores every register default.
// R2 - Channels one and three torch current is 25 mA per step of bits 5..3.
// R3 - Channel two torch current is 25 mA per step of bits 2..0.
// R4 - Channel two code 110 gives 150 mA, or 225 mA while transmit mask is one.
// R5 - Channel two code 111 gives 175 mA, or 325 mA while transmit mask is one.
// R6 - Both torch codes zero turn the LEDs off and select voltage regulation.
// R7 - Bits 7..6 of register 0x01 select shutdown, video, flash or constant V.
// R8 - Video mode shuts down unless the selector is rewritten within 13.0 s.
// R9 - A host write to the selector is copied to mode_mirror_val with a one-cycle mode_mirror_wr pulse.
// R10 - Channel two flash current is 25 mA per step of bits 5..0 up to 775 mA.
// R11 - Both flash codes zero keep the LEDs off and regulate the output voltage.
// R12 - Spare bit 6 of register 0x00 is stored and read back with no effect.
// R13 - A data byte is committed on the falling edge of its acknowledge.
// R14 - The reset pin low resets the serial interface and all registers.
// R15 - Reading an undefined register address returns zero.
module led_current_mode_registers #(
  parameter logic [31:0] TIMEOUT_CYCLES = led_ctrl_pkg::VL_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hw_reset_low,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic tx_mask,
  input wire logic [4:0] strobe_current_ch13,
  input wire logic [3:0] output_voltage_setting,
  output logic [2:0] torch_current_ch13,
  output logic [2:0] torch_current_ch2,
  output logic [5:0] strobe_current_ch2,
  output logic [1:0] op_mode,
  output logic [9:0] torch_ch13_ma,
  output logic [9:0] torch_ch2_ma,
  output logic [9:0] strobe_ch2_ma,
  output logic leds_off,
  output logic voltage_regulation,
  output logic [3:0] vout_setting,
  output logic mode_mirror_wr,
  output logic [1:0] mode_mirror_val,
  output logic soft_reset_pulse,
  output logic vl_timeout_pulse
);
  typedef enum logic [3:0] {
    st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
  } bus_state_e;

  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic nrst_s1_r, nrst_s2_r;
  logic bus_rst, reg_rst;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  bus_state_e state_r;
  logic [7:0] shift_r, tx_r, ptr_r, wbyte_r;
  logic [3:0] bit_cnt_r;
  logic rw_r;
  logic wr_en, wr_mode, soft_rst, expire;
  logic [7:0] vl_reg_r, mf_reg_r;
  logic [31:0] vl_cnt_r;
  logic [7:0] rd_now, rd_next;

  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input logic [7:0] r0,
                                          input logic [7:0] r1);
    logic [7:0] v;
    v = 8'h00; // R15
    if (a == led_ctrl_pkg::VL_CURRENT_OFS)
      v = r0;
    else if (a == led_ctrl_pkg::MODE_FLASH_OFS)
      v = r1;
    return v;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      nrst_s1_r <= 1'b1;
      nrst_s2_r <= 1'b1;
    end
    else
    begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      nrst_s1_r <= hw_reset_low;
      nrst_s2_r <= nrst_s1_r;
    end
  end

  assign bus_rst = !rstn || !nrst_s2_r; // R14
  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  assign start_cond = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_cond = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
  assign rd_now = read_reg(ptr_r, vl_reg_r, mf_reg_r);
  assign rd_next = read_reg(ptr_r + 8'h01, vl_reg_r, mf_reg_r);
  assign sda_out = 1'b0;
  assign wr_en = (state_r == st_wdata_ack) && scl_fall; // R13
  assign wr_mode = wr_en && (ptr_r == led_ctrl_pkg::MODE_FLASH_OFS);
  assign soft_rst = wr_en && (ptr_r == led_ctrl_pkg::VL_CURRENT_OFS) &&
    wbyte_r[led_ctrl_pkg::SOFT_RESET_BIT]; // R1
  assign reg_rst = bus_rst || soft_rst;

  always_ff @(posedge clk)
  begin
    if (bus_rst)
    begin
      state_r <= st_idle;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      wbyte_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      rw_r <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_cond)
    begin
      state_r <= st_addr;
      bit_cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_r <= st_idle;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        st_addr, st_reg, st_wdata:
        begin
          if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            bit_cnt_r <= 4'h0;
            sda_oe <= 1'b1;
            if (state_r == st_addr)
            begin
              rw_r <= shift_r[0];
              if (shift_r[7:1] == led_ctrl_pkg::SLAVE_ADDR)
                state_r <= st_addr_ack;
              else
              begin
                state_r <= st_idle;
                sda_oe <= 1'b0;
              end
            end
            else if (state_r == st_reg)
            begin
              ptr_r <= shift_r;
              state_r <= st_reg_ack;
            end
            else
            begin
              wbyte_r <= shift_r;
              state_r <= st_wdata_ack;
            end
          end
        end
        st_addr_ack:
        begin
          if (scl_fall)
          begin
            if (rw_r)
            begin
              tx_r <= rd_now;
              sda_oe <= !rd_now[7];
              bit_cnt_r <= 4'h1;
              state_r <= st_rdata;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_r <= st_reg;
            end
          end
        end
        st_reg_ack:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            state_r <= st_wdata;
          end
        end
        st_wdata_ack:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            ptr_r <= ptr_r + 8'h01;
            state_r <= st_wdata;
          end
        end
        st_rdata:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              sda_oe <= 1'b0;
              state_r <= st_rdata_ack;
            end
            else
            begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe <= !tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        st_rdata_ack:
        begin
          if (scl_rise && sda_s2_r)
            state_r <= st_idle;
          else if (scl_fall)
          begin
            ptr_r <= ptr_r + 8'h01;
            tx_r <= rd_next;
            sda_oe <= !rd_next[7];
            bit_cnt_r <= 4'h1;
            state_r <= st_rdata;
          end
        end
        default:
          state_r <= st_idle;
      endcase
    end
  end

  // Host write beats a timeout in the same cycle
  assign expire = (mf_reg_r[7:6] == led_ctrl_pkg::MODE_VIDEO) &&
    (vl_cnt_r >= TIMEOUT_CYCLES - 32'h1) && !wr_mode; // R8

  always_ff @(posedge clk)
  begin
    if (reg_rst)
    begin
      vl_reg_r <= led_ctrl_pkg::VL_CURRENT_RST; // R1
      mf_reg_r <= led_ctrl_pkg::MODE_FLASH_RST;
    end
    else if (wr_en && ptr_r == led_ctrl_pkg::VL_CURRENT_OFS)
      vl_reg_r <= wbyte_r; // R12
    else if (wr_mode)
      mf_reg_r <= wbyte_r;
    else if (expire)
      mf_reg_r[7:6] <= led_ctrl_pkg::MODE_SHUTDOWN; // R8
  end

  always_ff @(posedge clk)
  begin
    if (reg_rst || wr_mode ||
        mf_reg_r[7:6] != led_ctrl_pkg::MODE_VIDEO)
      vl_cnt_r <= 32'h0;
    else if (!expire)
      vl_cnt_r <= vl_cnt_r + 32'h1; // R8
  end

  always_ff @(posedge clk)
  begin
    if (bus_rst)
    begin
      mode_mirror_wr <= 1'b0;
      mode_mirror_val <= led_ctrl_pkg::MODE_SHUTDOWN;
      soft_reset_pulse <= 1'b0;
      vl_timeout_pulse <= 1'b0;
    end
    else
    begin
      mode_mirror_wr <= wr_mode || expire; // R9
      if (wr_mode)
        mode_mirror_val <= wbyte_r[7:6]; // R9
      else if (expire || soft_rst)
        mode_mirror_val <= led_ctrl_pkg::MODE_SHUTDOWN;
      soft_reset_pulse <= soft_rst;
      vl_timeout_pulse <= expire;
    end
  end

  logic [2:0] c13, c2;
  logic [5:0] fc2;
  logic [1:0] md;
  assign c13 = vl_reg_r[led_ctrl_pkg::CH13_LSB +: 3];
  assign c2 = vl_reg_r[led_ctrl_pkg::CH2_LSB +: 3];
  assign fc2 = mf_reg_r[led_ctrl_pkg::STROBE_LSB +: 6];
  assign md = mf_reg_r[led_ctrl_pkg::MODE_LSB +: 2];

  always_ff @(posedge clk)
  begin
    if (bus_rst)
    begin
      torch_current_ch13 <= 3'h0;
      torch_current_ch2 <= 3'h0;
      strobe_current_ch2 <= 6'h00;
      op_mode <= led_ctrl_pkg::MODE_SHUTDOWN;
      torch_ch13_ma <= 10'h000;
      torch_ch2_ma <= 10'h000;
      strobe_ch2_ma <= 10'h000;
      leds_off <= 1'b1;
      voltage_regulation <= 1'b0;
      vout_setting <= 4'h0;
    end
    else
    begin
      torch_current_ch13 <= c13;
      torch_current_ch2 <= c2;
      strobe_current_ch2 <= fc2;
      op_mode <= md; // R7
      torch_ch13_ma <= 10'(c13 * led_ctrl_pkg::STEP_MA); // R2
      if (tx_mask && c2 == led_ctrl_pkg::CH2_BOOST_A_CODE)
        torch_ch2_ma <= led_ctrl_pkg::CH2_BOOST_A_MA; // R4
      else if (tx_mask && c2 == led_ctrl_pkg::CH2_BOOST_B_CODE)
        torch_ch2_ma <= led_ctrl_pkg::CH2_BOOST_B_MA; // R5
      else
        torch_ch2_ma <= 10'(c2 * led_ctrl_pkg::STEP_MA); // R3
      if (fc2 > led_ctrl_pkg::STROBE_MAX_CODE)
        strobe_ch2_ma <= 10'(led_ctrl_pkg::STROBE_MAX_CODE *
                             led_ctrl_pkg::STEP_MA);
      else
        strobe_ch2_ma <= 10'(fc2 * led_ctrl_pkg::STEP_MA); // R10
      case (md)
        led_ctrl_pkg::MODE_VIDEO:
        begin
          leds_off <= (c13 == 3'h0) && (c2 == 3'h0); // R6
          voltage_regulation <= (c13 == 3'h0) && (c2 == 3'h0);
        end
        led_ctrl_pkg::MODE_FLASH:
        begin
          leds_off <= (fc2 == 6'h00) && (strobe_current_ch13 == 5'h00); // R11
          voltage_regulation <= (fc2 == 6'h00) &&
            (strobe_current_ch13 == 5'h00);
        end
        led_ctrl_pkg::MODE_CONST_V:
        begin
          leds_off <= 1'b1;
          voltage_regulation <= 1'b1;
        end
        default:
        begin
          leds_off <= 1'b1;
          voltage_regulation <= 1'b0;
        end
      endcase
      vout_setting <= output_voltage_setting; // R6
    end
  end
endmodule

// File: shared/led_ctrl_pkg.sv
package led_ctrl_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h33;
  localparam logic [7:0] VL_CURRENT_OFS = 8'h00;
  localparam logic [7:0] MODE_FLASH_OFS = 8'h01;
  localparam logic [7:0] VL_CURRENT_RST = 8'h0A;
  localparam logic [7:0] MODE_FLASH_RST = 8'h10;
  localparam int SOFT_RESET_BIT = 7;
  localparam int SPARE_BIT = 6;
  localparam int CH13_LSB = 3;
  localparam int CH2_LSB = 0;
  localparam int MODE_LSB = 6;
  localparam int STROBE_LSB = 0;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_VIDEO = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_CONST_V = 2'h3;
  localparam logic [9:0] STEP_MA = 10'h019;
  localparam logic [2:0] CH2_BOOST_A_CODE = 3'h6;
  localparam logic [2:0] CH2_BOOST_B_CODE = 3'h7;
  localparam logic [9:0] CH2_BOOST_A_MA = 10'h0E1;
  localparam logic [9:0] CH2_BOOST_B_MA = 10'h145;
  localparam logic [5:0] STROBE_MAX_CODE = 6'h1F;
  localparam longint CLK_HZ = 200000000;
  localparam longint VL_TIMEOUT_MS = 13000;
  localparam logic [31:0] VL_TIMEOUT_CYCLES =
    32'(VL_TIMEOUT_MS * CLK_HZ / 1000);
endpackage

// File: test/i2c_host_model.sv
module i2c_host_model (
  input wire logic clk,
  input wire logic dev_pull,
  output logic scl,
  output logic sda,
  output logic nack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low = 1'b0;
  logic scl_r = 1'b1;
  assign scl = scl_r;
  // Pull-up: released line reads high
  assign sda = !(host_low || dev_pull);
  task automatic ph();
    repeat (6) @(posedge clk);
  endtask
  task automatic start();
    host_low <= 1'b0;
    ph();
    scl_r <= 1'b1;
    ph();
    host_low <= 1'b1;
    ph();
    scl_r <= 1'b0;
    ph();
  endtask
  task automatic stop();
    host_low <= 1'b1;
    ph();
    scl_r <= 1'b1;
    ph();
    host_low <= 1'b0;
    ph();
  endtask
  task automatic bitx(input logic b, output logic r);
    host_low <= !b;
    ph();
    scl_r <= 1'b1;
    ph();
    r = sda;
    scl_r <= 1'b0;
    ph();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(a, r);
  endtask
  task automatic write(input logic [6:0] dev, input logic [7:0] a, d);
    logic [7:0] q;
    logic r0, r1, r2;
    start();
    xbyte({dev, 1'b0}, 1'b1, q, r0);
    xbyte(a, 1'b1, q, r1);
    xbyte(d, 1'b1, q, r2);
    stop();
    nack = r0 | r1 | r2;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic r;
    start();
    xbyte({led_ctrl_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, r);
    xbyte(a, 1'b1, q, r);
    start();
    xbyte({led_ctrl_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, r);
    // Single data byte, ended by no acknowledge
    xbyte(8'hFF, 1'b1, d, r);
    stop();
  endtask
endmodule

// File: test/led_current_mode_registers_sva.sv
module led_current_mode_registers_sva #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'hC8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hw_reset_low,
  input wire logic tx_mask,
  input wire logic [4:0] strobe_current_ch13,
  input wire logic [3:0] output_voltage_setting,
  input wire logic sda_oe,
  input wire logic [2:0] torch_current_ch13,
  input wire logic [2:0] torch_current_ch2,
  input wire logic [5:0] strobe_current_ch2,
  input wire logic [1:0] op_mode,
  input wire logic [9:0] torch_ch13_ma,
  input wire logic [9:0] torch_ch2_ma,
  input wire logic [9:0] strobe_ch2_ma,
  input wire logic leds_off,
  input wire logic voltage_regulation,
  input wire logic [3:0] vout_setting,
  input wire logic mode_mirror_wr,
  input wire logic [1:0] mode_mirror_val,
  input wire logic soft_reset_pulse,
  input wire logic vl_timeout_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_pin_low;
    !hw_reset_low [*4];
  endsequence
  a_soft_reset_defaults: assert property (soft_reset_pulse |-> ##[0:1]
    (torch_current_ch13 == 3'h1 && torch_current_ch2 == 3'h2
     && strobe_current_ch2 == 6'h10)) else $error("soft reset values");
  a_ch13_torch_ma: assert property (torch_ch13_ma ==
    10'(torch_current_ch13) * 10'h19) else $error("ch13 torch current");
  a_ch2_torch_ma: assert property (torch_ch2_ma ==
    (($past(tx_mask) && torch_current_ch2 == 3'h6) ? 10'hE1 :
     ($past(tx_mask) && torch_current_ch2 == 3'h7) ? 10'h145 :
     10'(torch_current_ch2) * 10'h19)) else $error("ch2 torch current");
  a_strobe_ch2_ma: assert property (strobe_current_ch2 <= 6'h1F |->
    strobe_ch2_ma == 10'(strobe_current_ch2) * 10'h19)
    else $error("ch2 flash current");
  a_video_leds_off: assert property (op_mode == 2'h1 |->
    leds_off == (torch_current_ch13 == 3'h0 && torch_current_ch2 == 3'h0)
    && voltage_regulation == leds_off) else $error("video leds off");
  a_flash_leds_off: assert property (op_mode == 2'h2 |->
    leds_off == (strobe_current_ch2 == 6'h0 && $past(strobe_current_ch13)
    == 5'h0)) else $error("flash leds off");
  a_vout_follows: assert property ($past(rstn) && hw_reset_low
    && $past(hw_reset_low, 4) |-> vout_setting ==
    $past(output_voltage_setting)) else $error("output voltage setting");
  a_mirror_value: assert property (mode_mirror_wr |=>
    op_mode == $past(mode_mirror_val)) else $error("mode mirror value");
  a_timeout_shuts_down: assert property (vl_timeout_pulse |->
    mode_mirror_wr && mode_mirror_val == 2'h0 ##[0:1] op_mode == 2'h0)
    else $error("video timeout");
  a_pin_reset_state: assert property (s_pin_low |-> op_mode == 2'h0
    && leds_off && !sda_oe) else $error("reset pin state");
endmodule

bind led_current_mode_registers led_current_mode_registers_sva #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_led_current_mode_registers_sva (.*);

// File: test/led_current_mode_registers_test.sv
module led_current_mode_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, hw_reset_low = 1'b1, tx_mask = 1'b0;
  logic [4:0] strobe_current_ch13 = 5'h0;
  logic [3:0] output_voltage_setting = 4'h5;
  logic scl, sda, sda_oe, nack, leds_off, voltage_regulation;
  logic mode_mirror_wr, soft_reset_pulse, vl_timeout_pulse;
  logic [2:0] torch_current_ch13, torch_current_ch2;
  logic [5:0] strobe_current_ch2;
  logic [1:0] op_mode, mode_mirror_val;
  logic [9:0] torch_ch13_ma, torch_ch2_ma, strobe_ch2_ma;
  logic [3:0] vout_setting;
  int mismatches = 0;
  int tests_run = 0;
  always #2.5 clk = !clk;
  i2c_host_model i_host (.clk, .dev_pull(sda_oe), .scl, .sda, .nack);
  led_current_mode_registers #(.TIMEOUT_CYCLES(32'h7D0))
    i_led_current_mode_registers (.clk, .rstn, .hw_reset_low,
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .tx_mask,
    .strobe_current_ch13, .output_voltage_setting, .torch_current_ch13,
    .torch_current_ch2, .strobe_current_ch2, .op_mode, .torch_ch13_ma,
    .torch_ch2_ma, .strobe_ch2_ma, .leds_off, .voltage_regulation,
    .vout_setting, .mode_mirror_wr, .mode_mirror_val, .soft_reset_pulse,
    .vl_timeout_pulse);
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    i_host.read(a, d);
    chk("register", {2'h0, e}, {2'h0, d});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_host.write(led_ctrl_pkg::SLAVE_ADDR, a, d);
  endtask
  task automatic fin(string s);
    $display("Test %s finished", s);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    rchk(8'h00, 8'h0A);
    rchk(8'h01, 8'h10);
    rchk(8'h02, 8'h00);
    rchk(8'h09, 8'h00);
    fin("defaults");
    wr(8'h00, 8'h7F);
    rchk(8'h00, 8'h7F);
    chk("ch13 mA", 10'hAF, torch_ch13_ma);
    chk("ch2 mA", 10'hAF, torch_ch2_ma);
    tx_mask <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ch2 mA", 10'h145, torch_ch2_ma);
    wr(8'h00, 8'h76);
    chk("ch2 mA", 10'hE1, torch_ch2_ma);
    tx_mask <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ch2 mA", 10'h96, torch_ch2_ma);
    fin("torch current");
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h01, {2'(m), 6'h1F});
      chk("mode", 10'(m), 10'(op_mode));
      chk("mirror", 10'(m), 10'(mode_mirror_val));
      chk("flash mA", 10'h307, strobe_ch2_ma);
    end
    wr(8'h01, 8'h80);
    chk("leds off", 10'h1, 10'(leds_off));
    chk("regulation", 10'h1, 10'(voltage_regulation));
    strobe_current_ch13 <= 5'h1;
    repeat (3) @(posedge clk);
    chk("leds off", 10'h0, 10'(leds_off));
    fin("modes");
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h40);
    chk("leds off", 10'h1, 10'(leds_off));
    chk("regulation", 10'h1, 10'(voltage_regulation));
    chk("vout", 10'h5, 10'(vout_setting));
    repeat (1200) @(posedge clk);
    wr(8'h01, 8'h40);
    repeat (1000) @(posedge clk);
    chk("mode", 10'h1, 10'(op_mode));
    repeat (1200) @(posedge clk);
    chk("mode", 10'h0, 10'(op_mode));
    rchk(8'h01, 8'h00);
    fin("video timeout");
    wr(8'h00, 8'h80);
    rchk(8'h00, 8'h0A);
    rchk(8'h01, 8'h10);
    i_host.write(7'h32, 8'h00, 8'h55);
    chk("nack", 10'h1, 10'(nack));
    rchk(8'h00, 8'h0A);
    fin("soft reset");
    wr(8'h01, 8'h7F);
    hw_reset_low <= 1'b0;
    repeat (10) @(posedge clk);
    hw_reset_low <= 1'b1;
    repeat (8) @(posedge clk);
    chk("mode", 10'h0, 10'(op_mode));
    rchk(8'h01, 8'h10);
    fin("reset pin");
    complete_run();
  end
endmodule
